// File: tks_cmd.sv
`timescale 1ns/100ps
`include "tks_defines.svh"
module tks_cmd #(
    parameter int KEYS = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire tks_pkg::tks_byte_t rxByte,
    output tks_pkg::tks_byte_t txByte,
    input wire logic [KEYS-1:0] keyDetect,
    input wire logic [KEYS*16-1:0] keySignal,
    input wire logic [KEYS*16-1:0] keyRef,
    input wire logic [KEYS*8-1:0] keyInteg,
    input wire logic [KEYS-1:0] calFailPulse,
    input wire logic [KEYS-1:0] calDonePulse,
    input wire logic [KEYS-1:0] calStartPulse,
    input wire logic [15:0] refUpper,
    input wire logic [15:0] refLower,
    input wire tks_pkg::tks_sys_t sysStatus,
    output logic nvmWrite,
    output logic [3:0] nvmKey,
    output logic [7:0] nvmData,
    output logic [KEYS*8-1:0] negThr
);
    tks_pkg::tks_scope_t scope_reg;
    logic [3:0] keySel_reg;
    logic [1:0] lineSel_reg;
    logic putMode_reg;
    logic argWait_reg;
    logic [7:0] argCmd_reg;
    logic [7:0] cmd_reg;
    logic [5:0] idx_reg;
    logic [5:0] len_reg;
    logic busy_reg;
    logic [KEYS-1:0] recal_reg;
    logic [KEYS-1:0] fail_reg;
    logic [2:0] tries_reg [KEYS];
    logic [3:0] errByte [KEYS];
    logic [KEYS-1:0] errAny;
    logic [3:0] firstKey_reg;
    logic [7:0] snapThr;
    logic [7:0] replyByte;
    logic [3:0] grpKey;
    logic [3:0] grpBits;
    logic [7:0] statusByte;
    logic [7:0] firstByte;

    genvar g;
    generate
        for (g = 0; g < KEYS; g++) begin : gKey
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    recal_reg[g] <= 1'b0;
                    fail_reg[g] <= 1'b0;
                    tries_reg[g] <= 3'h0;
                end else if (calStartPulse[g]) begin
                    recal_reg[g] <= 1'b1;
                    tries_reg[g] <= 3'h0;
                end else if (recal_reg[g] && calDonePulse[g]) begin
                    recal_reg[g] <= 1'b0;
                    fail_reg[g] <= 1'b0;
                end else if (recal_reg[g] && calFailPulse[g]) begin
                    if (tries_reg[g] == `TKS_CAL_TRIES - 3'h1) begin
                        recal_reg[g] <= 1'b0;
                        fail_reg[g] <= 1'b1;
                    end else begin
                        tries_reg[g] <= tries_reg[g] + 3'h1;
                    end
                end
            end
            always_comb begin
                errByte[g][`TKS_ERR_FAIL] = fail_reg[g];
                errByte[g][`TKS_ERR_RECAL] = recal_reg[g];
                errByte[g][`TKS_ERR_HIGH] = !recal_reg[g]
                    && keyRef[g*16 +: 16] > refUpper;
                errByte[g][`TKS_ERR_LOW] = !recal_reg[g]
                    && keyRef[g*16 +: 16] < refLower;
                errAny[g] = |errByte[g];
            end
        end
    endgenerate

    // keys are numbered row + 4*column
    function automatic logic [3:0] keyOf(input logic [1:0] row, input logic [1:0] col);
        keyOf = {col, row};
    endfunction : keyOf

    always_comb begin
        statusByte = 8'h00;
        statusByte[`TKS_ST_DETECT] = |keyDetect;
        statusByte[`TKS_ST_RECAL] = |recal_reg;
        statusByte[`TKS_ST_ERROR] = |errAny;
        statusByte[`TKS_ST_SYNC] = sysStatus.syncFail;
        statusByte[`TKS_ST_NVM] = sysStatus.nvmMismatch;
    end

    // Holds the last reported key while it stays active, so replies are stable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            firstKey_reg <= 4'h0;
        end else if (!keyDetect[firstKey_reg]) begin
            for (int k = KEYS - 1; k >= 0; k--) begin
                if (keyDetect[k]) begin
                    firstKey_reg <= 4'(k);
                end
            end
        end
    end

    always_comb begin
        logic [KEYS-1:0] others;
        others = keyDetect;
        others[firstKey_reg] = 1'b0;
        if (!keyDetect[firstKey_reg]) begin
            firstByte = `TKS_NO_KEY;
        end else begin
            firstByte = {|others, 3'h0, firstKey_reg};
        end
    end

    // round down onto the legal threshold list; values below 04 go up to 04
    always_comb begin
        logic [7:0] v;
        v = rxByte.data;
        if (v >= 8'h40) snapThr = 8'h40;
        else if (v >= 8'h37) snapThr = 8'h37;
        else if (v >= 8'h2D) snapThr = 8'h2D;
        else if (v >= 8'h23) snapThr = 8'h23;
        else if (v >= 8'h1E) snapThr = 8'h1E;
        else if (v >= 8'h19) snapThr = 8'h19;
        else if (v >= 8'h14) snapThr = 8'h14;
        else if (v >= 8'h11) snapThr = 8'h11;
        else if (v >= 8'h0F) snapThr = 8'h0F;
        else if (v >= 8'h0C) snapThr = 8'h0C;
        else if (v >= 8'h0A) snapThr = 8'h0A;
        else if (v >= 8'h08) snapThr = 8'h08;
        else if (v >= 8'h07) snapThr = 8'h07;
        else if (v >= 8'h06) snapThr = 8'h06;
        else if (v >= 8'h05) snapThr = 8'h05;
        else snapThr = 8'h04;
    end

    // Group replies: which key the current index addresses
    always_comb begin
        logic [5:0] k;
        k = (cmd_reg == `TKS_CMD_SIG_GRP || cmd_reg == `TKS_CMD_REF_GRP) ? idx_reg >> 1 : idx_reg;
        unique case (scope_reg)
            tks_pkg::SCOPE_ROW: grpKey = keyOf(lineSel_reg, k[1:0]);
            tks_pkg::SCOPE_COL: grpKey = keyOf(k[1:0], lineSel_reg);
            default: grpKey = k[3:0];
        endcase
    end

    function automatic logic [3:0] bitsOf(input logic [KEYS-1:0] v, input tks_pkg::tks_scope_t s,
                                          input logic [1:0] line, input logic [1:0] n,
                                          input logic [3:0] key);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 4; i++) begin
            unique case (s)
                tks_pkg::SCOPE_ROW: r[i] = v[keyOf(line, 2'(i))];
                tks_pkg::SCOPE_COL: r[i] = v[keyOf(2'(i), line)];
                tks_pkg::SCOPE_ALL: r[i] = v[{n, 2'(i)}];
                tks_pkg::SCOPE_KEY: r[i] = (i == 0) ? v[key] : 1'b0;
            endcase
        end
        bitsOf = r;
    endfunction : bitsOf

    always_comb begin
        logic [15:0] d;
        d = keyRef[grpKey*16 +: 16] - keySignal[grpKey*16 +: 16];
        grpBits = 4'h0;
        replyByte = 8'h00;
        unique case (cmd_reg)
            `TKS_CMD_SIG_GRP: replyByte = idx_reg[0] ? keySignal[grpKey*16+8 +: 8]
                                                     : keySignal[grpKey*16 +: 8];
            `TKS_CMD_REF_GRP: replyByte = idx_reg[0] ? keyRef[grpKey*16+8 +: 8]
                                                     : keyRef[grpKey*16 +: 8];
            `TKS_CMD_DELTA_GRP: begin
                if (keySignal[grpKey*16 +: 16] > keyRef[grpKey*16 +: 16]) replyByte = 8'h00;
                else if (d > 16'h00FF) replyByte = 8'hFF;
                else replyByte = d[7:0];
            end
            `TKS_CMD_INTEG_GRP: replyByte = keyInteg[grpKey*8 +: 8];
            `TKS_CMD_ERR_GRP: begin
                grpBits = bitsOf(errAny, scope_reg, lineSel_reg, idx_reg[1:0], keySel_reg);
                replyByte = (scope_reg == tks_pkg::SCOPE_KEY) ? {4'h0, errByte[keySel_reg]}
                                                     : {4'h0, grpBits};
            end
            `TKS_CMD_TOUCH_GRP: begin
                grpBits = bitsOf(keyDetect, scope_reg, lineSel_reg, idx_reg[1:0], keySel_reg);
                replyByte = {4'h0, grpBits};
            end
            default: replyByte = 8'h00;
        endcase
    end

    // Command decode and reply sequencing; one reply byte per cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scope_reg <= tks_pkg::SCOPE_ALL;
            keySel_reg <= 4'h0;
            lineSel_reg <= 2'h0;
            putMode_reg <= 1'b0;
            argWait_reg <= 1'b0;
            argCmd_reg <= 8'h00;
            cmd_reg <= 8'h00;
            idx_reg <= 6'h00;
            len_reg <= 6'h00;
            busy_reg <= 1'b0;
            txByte <= '0;
        end else begin
            txByte.valid <= 1'b0;
            if (busy_reg) begin
                txByte <= '{valid: 1'b1, data: replyByte};
                idx_reg <= idx_reg + 6'h01;
                busy_reg <= (idx_reg + 6'h01 != len_reg);
            end else if (rxByte.valid && argWait_reg) begin
                argWait_reg <= 1'b0;
                txByte <= '{valid: 1'b1, data: argCmd_reg};
                unique case (argCmd_reg)
                    `TKS_CMD_SCOPE_KEY: begin
                        scope_reg <= tks_pkg::SCOPE_KEY;
                        keySel_reg <= rxByte.data[3:0];
                    end
                    `TKS_CMD_SCOPE_ROW: begin
                        scope_reg <= tks_pkg::SCOPE_ROW;
                        lineSel_reg <= rxByte.data[1:0];
                    end
                    `TKS_CMD_SCOPE_COL: begin
                        scope_reg <= tks_pkg::SCOPE_COL;
                        lineSel_reg <= rxByte.data[1:0];
                    end
                    default: ;
                endcase
            end else if (rxByte.valid) begin
                cmd_reg <= rxByte.data;
                idx_reg <= 6'h00;
                unique case (rxByte.data)
                    `TKS_CMD_STATUS: txByte <= '{valid: 1'b1, data: statusByte};
                    `TKS_CMD_ERR_KEY: txByte <= '{valid: 1'b1, data: {4'h0, errByte[keySel_reg]}};
                    `TKS_CMD_FIRST_KEY: txByte <= '{valid: 1'b1, data: firstByte};
                    `TKS_CMD_SIG_GRP, `TKS_CMD_REF_GRP: begin
                        busy_reg <= 1'b1;
                        len_reg <= (scope_reg == tks_pkg::SCOPE_ROW
                            || scope_reg == tks_pkg::SCOPE_COL) ? 6'h08 : 6'h20;
                    end
                    `TKS_CMD_DELTA_GRP, `TKS_CMD_INTEG_GRP: begin
                        busy_reg <= 1'b1;
                        len_reg <= (scope_reg == tks_pkg::SCOPE_ROW
                            || scope_reg == tks_pkg::SCOPE_COL) ? 6'h04 : 6'h10;
                    end
                    `TKS_CMD_ERR_GRP, `TKS_CMD_TOUCH_GRP: begin
                        busy_reg <= 1'b1;
                        len_reg <= (scope_reg == tks_pkg::SCOPE_ALL) ? 6'h04 : 6'h01;
                    end
                    `TKS_CMD_GET_MODE, `TKS_CMD_PUT_MODE: begin
                        putMode_reg <= (rxByte.data == `TKS_CMD_PUT_MODE);
                        txByte <= '{valid: 1'b1, data: rxByte.data};
                    end
                    `TKS_CMD_SCOPE_ALL: begin
                        scope_reg <= tks_pkg::SCOPE_ALL;
                        txByte <= '{valid: 1'b1, data: rxByte.data};
                    end
                    `TKS_CMD_SCOPE_KEY, `TKS_CMD_SCOPE_ROW, `TKS_CMD_SCOPE_COL: begin
                        argWait_reg <= 1'b1;
                        argCmd_reg <= rxByte.data;
                    end
                    `TKS_CMD_NEG_THR: begin
                        if (putMode_reg) begin
                            argWait_reg <= 1'b1;
                            argCmd_reg <= rxByte.data;
                        end else begin
                            txByte <= '{valid: 1'b1, data: negThr[keySel_reg*8 +: 8]};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // threshold store runs beside sensing, live in the same cycle as the echo
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            negThr <= {KEYS{`TKS_THR_RESET}};
            nvmWrite <= 1'b0;
            nvmKey <= 4'h0;
            nvmData <= 8'h00;
        end else begin
            nvmWrite <= 1'b0;
            if (!busy_reg && rxByte.valid && argWait_reg && argCmd_reg == `TKS_CMD_NEG_THR) begin
                nvmWrite <= 1'b1;
                nvmKey <= keySel_reg;
                nvmData <= snapThr;
                for (int k = 0; k < KEYS; k++) begin
                    if ((scope_reg == tks_pkg::SCOPE_ALL)
                        || (scope_reg == tks_pkg::SCOPE_KEY && 4'(k) == keySel_reg)
                        || (scope_reg == tks_pkg::SCOPE_ROW && 2'(k) == lineSel_reg)
                        || (scope_reg == tks_pkg::SCOPE_COL && 2'(k >> 2) == lineSel_reg)) begin
                        negThr[k*8 +: 8] <= snapThr;
                    end
                end
            end
        end
    end

    property p_status_zero;
        @(posedge clk) disable iff (!nrst)
        statusByte[7:5] == 3'h0 && statusByte[`TKS_ST_ERROR] == |errAny;
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("status upper bits");

    property p_recal_clear;
        @(posedge clk) disable iff (!nrst)
        recal_reg[0] |-> errByte[0][3:2] == 2'h0;
    endproperty
    a_recal_clear: assert property (p_recal_clear) else $error("flags during recal");

    property p_no_key;
        @(posedge clk) disable iff (!nrst)
        keyDetect == '0 |-> firstByte == `TKS_NO_KEY;
    endproperty
    a_no_key: assert property (p_no_key) else $error("no key not FF");

    property p_first_valid;
        @(posedge clk) disable iff (!nrst)
        firstByte != `TKS_NO_KEY |-> keyDetect[firstByte[3:0]];
    endproperty
    a_first_valid: assert property (p_first_valid) else $error("first key inactive");

    property p_scope_reset;
        @(posedge clk) $rose(nrst) |-> scope_reg == tks_pkg::SCOPE_ALL;
    endproperty
    a_scope_reset: assert property (p_scope_reset) else $error("scope not all");

    property p_group_len;
        @(posedge clk) disable iff (!nrst)
        rxByte.valid && !busy_reg && !argWait_reg && rxByte.data == `TKS_CMD_SIG_GRP
            && scope_reg == tks_pkg::SCOPE_ALL
            |=> busy_reg ##31 (busy_reg && idx_reg == 6'h1F) ##1 !busy_reg;
    endproperty
    a_group_len: assert property (p_group_len) else $error("signal reply length");

    property p_fail_after;
        @(posedge clk) disable iff (!nrst)
        $rose(fail_reg[0]) |-> $past(tries_reg[0]) == `TKS_CAL_TRIES - 3'h1;
    endproperty
    a_fail_after: assert property (p_fail_after) else $error("fail flag early");

    property p_thr_legal;
        @(posedge clk) disable iff (!nrst)
        nvmWrite |-> nvmData >= 8'h04 && nvmData <= 8'h40 && nvmData <= $past(rxByte.data);
    endproperty
    a_thr_legal: assert property (p_thr_legal) else $error("threshold out of range");
endmodule : tks_cmd

// File: tks_defines.svh
`ifndef TKS_DEFINES_SVH
`define TKS_DEFINES_SVH
`define TKS_CMD_STATUS 8'h37
`define TKS_CMD_SIG_GRP 8'h20
`define TKS_CMD_DELTA_GRP 8'h21
`define TKS_CMD_REF_GRP 8'h22
`define TKS_CMD_INTEG_GRP 8'h25
`define TKS_CMD_ERR_KEY 8'h65
`define TKS_CMD_ERR_GRP 8'h45
`define TKS_CMD_FIRST_KEY 8'h6B
`define TKS_CMD_TOUCH_GRP 8'h4B
`define TKS_CMD_NEG_THR 8'h01
`define TKS_CMD_GET_MODE 8'h67
`define TKS_CMD_PUT_MODE 8'h70
`define TKS_CMD_SCOPE_KEY 8'h73
`define TKS_CMD_SCOPE_ALL 8'h53
`define TKS_CMD_SCOPE_ROW 8'h78
`define TKS_CMD_SCOPE_COL 8'h79
`define TKS_NO_KEY 8'hFF
`define TKS_MORE_BIT 7
`define TKS_ERR_FAIL 0
`define TKS_ERR_RECAL 1
`define TKS_ERR_HIGH 2
`define TKS_ERR_LOW 3
`define TKS_ST_DETECT 0
`define TKS_ST_RECAL 1
`define TKS_ST_ERROR 2
`define TKS_ST_SYNC 3
`define TKS_ST_NVM 4
`define TKS_CAL_TRIES 3'h5
`define TKS_THR_RESET 8'h0A
`endif

// File: tks_host_model.sv
`timescale 1ns/100ps
module tks_host_model (
    input wire logic clk,
    output tks_pkg::tks_byte_t rxByte,
    input wire tks_pkg::tks_byte_t txByte
);
    logic [7:0] got[$];
    initial begin
        rxByte = 9'h000;
    end
    // Reply bytes stand one cycle each, so every edge is looked at
    always @(posedge clk) begin
        if (txByte.valid === 1'b1) begin
            got.push_back(txByte.data);
        end
    end
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        rxByte.data = b;
        rxByte.valid = 1'b1;
        @(negedge clk);
        rxByte.valid = 1'b0;
        // Idle data flips so a stale byte can never pass for a fresh one
        rxByte.data = ~b;
    endtask : send
    // Rest between commands, long enough for a setup store to finish
    task automatic gap;
        repeat (4) @(negedge clk);
    endtask : gap
endmodule : tks_host_model

// File: tks_pkg.sv
package tks_pkg;
    typedef enum logic [1:0] {SCOPE_KEY, SCOPE_ROW, SCOPE_COL, SCOPE_ALL} tks_scope_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } tks_byte_t;
    typedef struct packed {
        logic syncFail;
        logic nvmMismatch;
    } tks_sys_t;
endpackage : tks_pkg

// File: touch_key_status_commands_tb_top.sv
`timescale 1ns/100ps
`include "tks_defines.svh"
module touch_key_status_commands_tb_top;
    logic clk;
    logic nrst;
    tks_pkg::tks_byte_t rxByte;
    tks_pkg::tks_byte_t txByte;
    logic [15:0] keyDetect;
    logic [255:0] keySignal;
    logic [255:0] keyRef;
    logic [127:0] keyInteg;
    logic [15:0] calFailPulse;
    logic [15:0] calDonePulse;
    logic [15:0] calStartPulse;
    logic [15:0] refUpper;
    logic [15:0] refLower;
    tks_pkg::tks_sys_t sysStatus;
    logic nvmWrite;
    logic [3:0] nvmKey;
    logic [7:0] nvmData;
    logic [127:0] negThr;
    int fails;
    int checksDone;
    int nvmCount;
    logic [7:0] nvmSeen;
    logic [3:0] nvmKeySeen;
    tks_cmd #(.KEYS(16)) DUT (.clk(clk), .nrst(nrst), .rxByte(rxByte), .txByte(txByte),
        .keyDetect(keyDetect), .keySignal(keySignal), .keyRef(keyRef), .keyInteg(keyInteg),
        .calFailPulse(calFailPulse), .calDonePulse(calDonePulse),
        .calStartPulse(calStartPulse), .refUpper(refUpper), .refLower(refLower),
        .sysStatus(sysStatus), .nvmWrite(nvmWrite), .nvmKey(nvmKey), .nvmData(nvmData),
        .negThr(negThr));
    tks_host_model host (.clk(clk), .rxByte(rxByte), .txByte(txByte));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (nvmWrite === 1'b1) begin
            nvmCount <= nvmCount + 1;
            nvmSeen <= nvmData;
            nvmKeySeen <= nvmKey;
        end
    end
    function automatic logic [15:0] sig(input int k);
        return 16'h4000 + 16'(k) * 16'h0101;
    endfunction : sig
    // Three bands: delta above 255, reference below signal, small delta
    function automatic logic [15:0] refv(input int k);
        return (k < 4) ? sig(k) + 16'h0180 : (k < 8) ? sig(k) - 16'h0001 : sig(k) + 16'(k);
    endfunction : refv
    function automatic logic [15:0] dlt(input int k);
        if (refv(k) <= sig(k)) begin
            return 16'h0000;
        end
        return (refv(k) - sig(k) > 16'h00FF) ? 16'h00FF : refv(k) - sig(k);
    endfunction : dlt
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input logic [7:0] cmd, input logic hasArg, input logic [7:0] arg,
                       input int n);
        int i;
        host.got.delete();
        host.send(cmd);
        if (hasArg) begin
            host.send(arg);
        end
        i = 0;
        while (host.got.size() < n && i < 100) begin
            @(negedge clk);
            i++;
        end
        if (host.got.size() < n) begin
            fails++;
            $display("unexpected at %0t: no reply to %h", $time, cmd);
            final_report();
        end
        host.gap();
        check(8'(host.got.size()), 8'(n));
    endtask : run
    task automatic echo(input logic [7:0] cmd, input logic hasArg, input logic [7:0] arg);
        run(cmd, hasArg, arg, 1);
        check(host.got[0], cmd);
    endtask : echo
    task automatic expBytes(input logic [31:0] exp, input int n);
        for (int i = 0; i < n; i++) begin
            check(host.got[i], exp[i * 8 +: 8]);
        end
    endtask : expBytes
    // Mode 0 all keys, 1 row, 2 column
    task automatic groupRead(input logic [7:0] cmd, input int mode, input int line);
        int nk;
        int bpk;
        int k;
        logic [15:0] v;
        nk = (mode == 0) ? 16 : 4;
        bpk = (cmd == `TKS_CMD_SIG_GRP || cmd == `TKS_CMD_REF_GRP) ? 2 : 1;
        run(cmd, 1'b0, 8'h00, nk * bpk);
        for (int i = 0; i < nk; i++) begin
            k = (mode == 0) ? i : (mode == 1) ? line + 4 * i : 4 * line + i;
            case (cmd)
                `TKS_CMD_SIG_GRP: v = sig(k);
                `TKS_CMD_REF_GRP: v = refv(k);
                `TKS_CMD_DELTA_GRP: v = dlt(k);
                default: v = {8'h00, 8'hC0 + 8'(k)};
            endcase
            for (int b = 0; b < bpk; b++) begin
                check(host.got[i * bpk + b], v[b * 8 +: 8]);
            end
        end
    endtask : groupRead
    task automatic pulse(input int kind);
        @(negedge clk);
        {calDonePulse[0], calFailPulse[0], calStartPulse[0]} = 3'(1 << kind);
        @(negedge clk);
        {calDonePulse[0], calFailPulse[0], calStartPulse[0]} = 3'h0;
    endtask : pulse
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        fails = 0;
        checksDone = 0;
        nvmCount = 0;
        keyDetect = 16'h0020;
        {calFailPulse, calDonePulse, calStartPulse} = '0;
        refUpper = 16'hFFFF;
        refLower = 16'h0000;
        sysStatus = 2'h3;
        for (int k = 0; k < 16; k++) begin
            keySignal[k * 16 +: 16] = sig(k);
            keyRef[k * 16 +: 16] = refv(k);
            keyInteg[k * 8 +: 8] = 8'hC0 + 8'(k);
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        run(`TKS_CMD_STATUS, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h19);
        // Default scope must already be all keys
        for (int c = 0; c < 4; c++) begin
            groupRead(8'(32'h25222120 >> (c * 8)), 0, 0);
        end
        echo(`TKS_CMD_SCOPE_ROW, 1'b1, 8'h02);
        groupRead(`TKS_CMD_SIG_GRP, 1, 2);
        groupRead(`TKS_CMD_INTEG_GRP, 1, 2);
        echo(`TKS_CMD_SCOPE_COL, 1'b1, 8'h01);
        groupRead(`TKS_CMD_REF_GRP, 2, 1);
        groupRead(`TKS_CMD_DELTA_GRP, 2, 1);
        $display("test status and groups done");
        run(`TKS_CMD_FIRST_KEY, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h05);
        @(negedge clk);
        keyDetect = 16'h0220;
        host.gap();
        run(`TKS_CMD_FIRST_KEY, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h85);
        echo(`TKS_CMD_SCOPE_ALL, 1'b0, 8'h00);
        run(`TKS_CMD_TOUCH_GRP, 1'b0, 8'h00, 4);
        expBytes(32'h00020200, 4);
        echo(`TKS_CMD_SCOPE_ROW, 1'b1, 8'h01);
        run(`TKS_CMD_TOUCH_GRP, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h06);
        echo(`TKS_CMD_SCOPE_KEY, 1'b1, 8'h09);
        run(`TKS_CMD_TOUCH_GRP, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h01);
        @(negedge clk);
        keyDetect = 16'h0200;
        host.gap();
        run(`TKS_CMD_FIRST_KEY, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h09);
        @(negedge clk);
        keyDetect = 16'h0000;
        host.gap();
        run(`TKS_CMD_FIRST_KEY, 1'b0, 8'h00, 1);
        check(host.got[0], `TKS_NO_KEY);
        $display("test touch done");
        echo(`TKS_CMD_SCOPE_KEY, 1'b1, 8'h00);
        refLower = 16'h4200;
        pulse(0);
        run(`TKS_CMD_ERR_KEY, 1'b0, 8'h00, 1);
        check(host.got[0] & 8'h0F, 8'h02);
        for (int f = 1; f <= 5; f++) begin
            pulse(1);
            run(`TKS_CMD_ERR_KEY, 1'b0, 8'h00, 1);
            check(host.got[0] & 8'h01, (f == 5) ? 8'h01 : 8'h00);
        end
        // Failure flag only drops when a later recalibration completes
        pulse(0);
        pulse(2);
        refUpper = 16'h4F10;
        run(`TKS_CMD_ERR_KEY, 1'b0, 8'h00, 1);
        check(host.got[0] & 8'h0F, 8'h08);
        sysStatus = 2'h1;
        run(`TKS_CMD_STATUS, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h14);
        echo(`TKS_CMD_SCOPE_ALL, 1'b0, 8'h00);
        run(`TKS_CMD_ERR_GRP, 1'b0, 8'h00, 4);
        expBytes(32'h08000001, 4);
        echo(`TKS_CMD_SCOPE_COL, 1'b1, 8'h03);
        run(`TKS_CMD_ERR_GRP, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h08);
        echo(`TKS_CMD_SCOPE_ROW, 1'b1, 8'h00);
        run(`TKS_CMD_ERR_GRP, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h01);
        echo(`TKS_CMD_SCOPE_KEY, 1'b1, 8'h0F);
        run(`TKS_CMD_ERR_GRP, 1'b0, 8'h00, 1);
        check(host.got[0] & 8'h0F, 8'h04);
        $display("test errors done");
        check(negThr[7:0], `TKS_THR_RESET);
        echo(`TKS_CMD_PUT_MODE, 1'b0, 8'h00);
        echo(`TKS_CMD_SCOPE_KEY, 1'b1, 8'h02);
        // Arguments stay within 4..64
        for (int t = 0; t < 4; t++) begin
            echo(`TKS_CMD_NEG_THR, 1'b1, 8'(32'h40130B09 >> (t * 8)));
            check(negThr[23:16], 8'(32'h40110A08 >> (t * 8)));
            check(nvmSeen, 8'(32'h40110A08 >> (t * 8)));
        end
        check(8'(nvmCount), 8'h04);
        check({4'h0, nvmKeySeen}, 8'h02);
        check(negThr[31:24], `TKS_THR_RESET);
        echo(`TKS_CMD_SCOPE_ALL, 1'b0, 8'h00);
        echo(`TKS_CMD_NEG_THR, 1'b1, 8'h2E);
        check(negThr[127:120], 8'h2D);
        check(negThr[7:0], 8'h2D);
        echo(`TKS_CMD_GET_MODE, 1'b0, 8'h00);
        run(`TKS_CMD_NEG_THR, 1'b0, 8'h00, 1);
        check(host.got[0], 8'h2D);
        $display("test threshold done");
        final_report();
    end
endmodule : touch_key_status_commands_tb_top
